// File: common/link_decoder_consts.svh
// Constants for the display link packet decoder: packet types, sizes and reset values.
// Assumes inclusion by the design modules of the decoder: the packet decoder and the pixel unpacker.
`ifndef LINK_DECODER_CONSTS_SVH
`define LINK_DECODER_CONSTS_SVH

`define DT_SHORT_WRITE_LOW 3'h5      // Short command write, low type bits
`define DT_READ_REQ        6'h06     // Command read request
`define DT_MAX_RETURN      6'h37     // Set maximum return size
`define DT_NULL            6'h09     // Null long packet
`define DT_BLANK           6'h19     // Blanking long packet
`define DT_GENERIC_LONG    6'h29     // Generic non-image long packet
`define DT_LONG_WRITE      6'h39     // Command long write
`define DT_PIX16           6'h0e     // 16-bit packed pixels
`define DT_PIX18           6'h1e     // 18-bit packed pixels
`define MAX_RET_RESET      16'h0001  // Maximum return size after reset
`define READ_HDR_BYTES     3'h1      // Command byte only
`define LIMIT_HDR_BYTES    3'h2      // Two limit bytes
`define WC_HDR_BYTES       3'h2      // Two count bytes
`define CSUM_BYTES         16'h0002  // Checksum closing a long packet
`define PIX16_BITS         5'h10     // Bits in one 16-bit pixel
`define PIX18_BITS         5'h12     // Bits in one 18-bit pixel

`endif

// File: common/link_decoder_pkg.sv
// Types shared by the display link packet decoder and its pixel unpacker.
// Assumes the constants header sits beside it on the include path.
package link_decoder_pkg;

    // One received byte from the link's byte clock domain
    typedef struct packed {
        logic       valid;
        logic       sop;    // First byte of a packet (identifier)
        logic [7:0] data;
    } rx_byte_t;

    // Command byte or parameter byte handed to the command engine
    typedef struct packed {
        logic       valid;
        logic       param;  // Low: command byte, high: parameter
        logic [7:0] data;
    } cmd_out_t;

    // Payload byte of a long packet
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [5:0] ptype;
        logic [7:0] data;
    } payload_t;

    // One unpacked pixel, components right aligned
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } pixel_t;

    // Request to the reverse-direction transmitter
    typedef struct packed {
        logic        valid;
        logic        ack;         // Plain acknowledge
        logic        err_report;  // Acknowledge with error report
        logic        read;        // Read data follows (after any report)
        logic [7:0]  read_cmd;
        logic [15:0] max_return;
    } resp_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HEAD = 5'h02,
        ST_LPAY = 5'h04,
        ST_CSUM = 5'h08,
        ST_SKIP = 5'h10
    } dec_state_t;

    typedef enum logic [1:0] {
        LAST_NONE  = 2'h0,
        LAST_WRITE = 2'h1,
        LAST_READ  = 2'h2
    } last_kind_t;

    typedef struct packed {
        dec_state_t  st;
        logic [5:0]  dt;
        logic [15:0] cnt;
        logic [2:0]  pos;
        logic [15:0] wc;
        logic        first;
        last_kind_t  last_kind;
        logic [7:0]  read_cmd;
        logic        err;
        logic        fixed;
        logic [15:0] lim;
        logic [15:0] max_ret;
        cmd_out_t    cmd;
        payload_t    pay;
        resp_t       resp;
        logic        pix_valid;
        logic        pix_last;
        logic        pix18;
        logic [7:0]  pix_byte;
    } dec_regs_t;

    typedef struct packed {
        logic [31:0] acc;
        logic [4:0]  fill;
        pixel_t      pix;
    } unpack_regs_t;

endpackage

// File: tb/host_link_model.sv
// Host model: sends link packets and turnaround pulses to the decoder.
// Assumes the bench calls its tasks; all lines change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module host_link_model
    import link_decoder_pkg::*;
(
    input  wire logic CLOCK,      // Byte clock
    output rx_byte_t  RX,         // Packet bytes
    output logic      TURNAROUND, // Handover pulse
    output logic      ECC_ERR,    // Header error
    output logic      ECC_FIXED   // Error corrected
);
    // One set of line values per byte clock
    task automatic put(input logic [12:0] x);
        @(negedge CLOCK);
        {TURNAROUND, ECC_ERR, ECC_FIXED, RX} = x;
    endtask
    // Idle lines show a changed pattern, never the last byte held
    task automatic pkt(input logic [5:0] dt, input logic [7:0] b[$],
                       input logic [1:0] e, input logic lg);
        put({5'h3, 2'h0, dt});
        if (lg) begin
            put({5'h2, 8'(b.size())});
            put({5'h2, 8'h00});
            put({1'b0, e, 2'h2, 8'h5a});
        end
        foreach (b[i]) put({5'h2, b[i]});
        if (lg) begin
            put({5'h2, 8'hc3});
            put({5'h2, 8'h3c});
        end
        else put({1'b0, e, 2'h2, 8'h5a});
        put({5'h0, 8'ha5});
    endtask
    // Handover pulse after a transmission
    task automatic turn();
        put(13'h1000);
        put(13'h0);
    endtask
    initial {TURNAROUND, ECC_ERR, ECC_FIXED, RX} = 13'h0;
endmodule
`default_nettype wire

// File: tb/test_display_link_packet_decoder.sv
// Bench: host model drives, a watcher compares each output pulse
// with the oldest note in a queue. Checksum error is raised for one long write.
`timescale 1ns/1ns
`default_nettype none
module test_display_link_packet_decoder
    import link_decoder_pkg::*;
;
    logic        CLOCK, SRST, BIDIR_LINK, TURNAROUND, ECC_ERR, ECC_FIXED, CSUM_ERR;
    rx_byte_t    RX;
    cmd_out_t    CMD;
    payload_t    PAYLOAD;
    pixel_t      PIXEL;
    resp_t       RESP;
    logic [15:0] MAX_RETURN, lim;
    logic [71:0] s;
    logic [17:0] v;
    logic [7:0]  b[$];
    logic [31:0] exp_q[$];
    int          err_count = 0, check_count = 0, n, w;
    host_link_model u_host (.CLOCK(CLOCK), .RX(RX), .TURNAROUND(TURNAROUND),
        .ECC_ERR(ECC_ERR), .ECC_FIXED(ECC_FIXED));
    display_link_packet_decoder u_dut (.CLOCK(CLOCK), .SRST(SRST), .RX(RX),
        .TURNAROUND(TURNAROUND), .BIDIR_LINK(BIDIR_LINK), .ECC_ERR(ECC_ERR),
        .ECC_FIXED(ECC_FIXED), .CSUM_ERR(CSUM_ERR), .CMD(CMD), .PAYLOAD(PAYLOAD),
        .PIXEL(PIXEL), .RESP(RESP), .MAX_RETURN(MAX_RETURN));
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // A pulse with no note waiting meets unknown and fails
    task automatic take(input string what, input logic [31:0] g);
        chk(what, exp_q.size() > 0 ? exp_q.pop_front() : 'x, g);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    // Watcher, idle in reset while outputs are still unknown; the read
    // command is masked when no read data follows
    always @(negedge CLOCK) if (SRST === 1'b0) begin
        if (CMD.valid !== 1'b0) take("cmd", {4'h1, 19'h0, CMD.param, CMD.data});
        if (PAYLOAD.valid !== 1'b0) take("payload", {4'h2, 13'h0, PAYLOAD.last,
            PAYLOAD.ptype, PAYLOAD.data});
        if (RESP.valid !== 1'b0) take("resp", {4'h3, 17'h0, RESP.read ? 1'b0 : RESP.ack,
            RESP.err_report, RESP.read, RESP.read ? RESP.read_cmd : 8'h0});
        if (PIXEL.valid !== 1'b0) take("pixel", {4'h4, 9'h0, PIXEL.last, PIXEL.red,
            PIXEL.green, PIXEL.blue});
    end
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(40 * 5000);
        err_count++;
        conclude();
    end
    initial begin
        SRST = 1'b1;
        CSUM_ERR = 1'b0;
        BIDIR_LINK = 1'b1;
        void'($urandom(32));
        repeat (5) @(negedge CLOCK);
        SRST = 1'b0;
        chk("limit", 32'h1, {16'h0, MAX_RETURN});
        for (int k = 0; k < 7; k++) begin
            b = {};
            for (int i = 0; i <= k; i++) begin
                b.push_back(8'($urandom));
                exp_q.push_back({4'h1, 19'h0, i != 0, b[i]});
            end
            u_host.pkt({3'(k + 1), 3'h5}, b, {k == 6, 1'b0}, 1'b0);
            exp_q.push_back({4'h3, 17'h0, k != 6, k == 6, 1'b0, 8'h0});
            u_host.turn();
        end
        lim = 16'($urandom);
        b = {lim[7:0], lim[15:8]};
        u_host.pkt(6'h37, b, 2'h0, 1'b0);
        @(negedge CLOCK);
        chk("limit", {16'h0, lim}, {16'h0, MAX_RETURN});
        BIDIR_LINK = 1'b0;
        b = {~lim[7:0], lim[15:8]};
        u_host.pkt(6'h37, b, 2'h0, 1'b0);
        u_host.turn();
        chk("limit", {16'h0, lim}, {16'h0, MAX_RETURN});
        BIDIR_LINK = 1'b1;
        $display("test writes and limit done");
        for (int k = 0; k < 3; k++) begin
            b = {8'($urandom)};
            exp_q.push_back({4'h1, 19'h0, 1'b0, b[0]});
            u_host.pkt(6'h06, b, {k != 0, k == 1}, 1'b0);
            exp_q.push_back({4'h3, 17'h0, 1'b0, k != 0, k != 2,
                k != 2 ? b[0] : 8'h0});
            u_host.turn();
            chk("max_return", {16'h0, lim}, {16'h0, RESP.max_return});
        end
        for (int t = 0; t < 4; t++) begin
            b = {};
            n = 1 + $urandom % 6;
            for (int i = 0; i < n; i++) begin
                b.push_back(8'($urandom));
                if (t == 3 && i == 0) exp_q.push_back({4'h1, 20'h0, b[0]});
                else if (t != 0) exp_q.push_back({4'h2, 13'h0, i == n - 1, 2'(t), 4'h9,
                    b[i]});
            end
            // Only the long write closes with a bad checksum
            CSUM_ERR = (t == 3);
            u_host.pkt({2'(t), 4'h9}, b, 2'h0, 1'b1);
        end
        CSUM_ERR = 1'b0;
        exp_q.push_back({4'h3, 17'h0, 3'h2, 8'h0});
        u_host.turn();
        $display("test reads and long packets done");
        for (int t = 0; t < 4; t++) begin
            b = {};
            n = 2 * t + 2 + t % 2;
            w = t[0] ? 18 : 16;
            for (int i = 0; i < n; i++) begin
                b.push_back(8'($urandom));
                s[8 * i +: 8] = b[i];
            end
            for (int j = 0; j < n * 8 / w; j++) begin
                v = s[j * w +: 18];
                v = t[0] ? {v[5:0], v[11:6], v[17:12]} : {1'b0, v[4:0], v[10:5], 1'b0, v[15:11]};
                exp_q.push_back({4'h4, 9'h0, j == n * 8 / w - 1, v});
            end
            u_host.pkt({1'b0, t[0], 4'he}, b, 2'h0, 1'b1);
        end
        repeat (10) @(negedge CLOCK);
        $display("test pixels done");
        chk("pending", 32'h0, 32'(exp_q.size()));
        conclude();
    end
endmodule
`default_nettype wire

// File: verilog/display_link_packet_decoder.sv
// Peripheral-side packet decoder of a serial display link: parses host packets
// and requests acknowledge, error report and read responses after turnaround.
// Assumes a byte stream from the lane layer, with header and checksum error
// flags from separate checkers aligned to the bytes they cover.
//
// Behaviour
// - Short command packet: command byte after identifier, then zero to six parameters.
// - Type bits 5:3 hold parameter count plus one, giving packet length.
// - After turnaround, short write gets acknowledge, or error report when errors seen.
// - On a one-way link, turnaround is ignored and nothing is answered.
// - Read request type 06h carries a command byte; answer depends on it.
// - On error send error report; a corrected error also sends the read data.
// - With no error, send the requested read packet with enabled checks.
// - Read request ends a transmission; turnaround follows, answer, then bus back.
// - Long write 39h: count, check, command byte, count minus one bytes, checksum.
// - Type 37h carries a two-byte return limit, low byte first.
// - A one-way link ignores the return limit command entirely.
// - Return limit is one after reset.
// - Null long packet 09h payload is discarded.
// - Blanking long packet 19h: count bytes of payload, then checksum.
// - Generic long packet 29h has the same long layout.
// - 16-bit pixels 0Eh: red five, green six, blue five, first bit lowest.
// - 18-bit pixels 1Eh: six bits each, aligning every four pixels.
// - Partial final byte bits of an 18-bit line are dropped.
`timescale 1ns/1ns
`default_nettype none
`include "link_decoder_consts.svh"

module display_link_packet_decoder
    import link_decoder_pkg::*;
(
    input  wire logic       CLOCK,        // Byte clock, 25 MHz
    input  wire logic       SRST,         // Synchronous reset, active high
    input  wire rx_byte_t   RX,           // Received byte stream
    input  wire logic       TURNAROUND,   // Host handed the link over (pulse)
    input  wire logic       BIDIR_LINK,   // High: link can answer back
    input  wire logic       ECC_ERR,      // Header error, with the check byte
    input  wire logic       ECC_FIXED,    // Header error was corrected
    input  wire logic       CSUM_ERR,     // Payload error, with last checksum byte
    output cmd_out_t        CMD,          // Command and parameter bytes
    output payload_t        PAYLOAD,      // Long packet payload bytes
    output pixel_t          PIXEL,        // Unpacked pixels
    output resp_t           RESP,         // Request to reverse transmitter
    output logic [15:0]     MAX_RETURN    // Current return size limit
);

    dec_regs_t s_r;
    dec_regs_t s_nxt;
    logic      new_pkt;
    logic      byte_in;
    logic      hard_err;

    // A short command write is any type whose low three bits are 101
    function automatic logic is_short_write(input logic [5:0] t);
        return t[2:0] == `DT_SHORT_WRITE_LOW;
    endfunction

    // Long packets this block accepts
    function automatic logic is_long(input logic [5:0] t);
        return t == `DT_NULL || t == `DT_BLANK || t == `DT_GENERIC_LONG ||
               t == `DT_LONG_WRITE || t == `DT_PIX16 || t == `DT_PIX18;
    endfunction

    assign new_pkt = RX.valid && RX.sop;
    assign byte_in = RX.valid && !RX.sop;
    // An uncorrected header error leaves the packet contents untrusted
    assign hard_err = ECC_ERR && !ECC_FIXED;

    // Packet parser and response decision
    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd.valid = 1'b0;
        s_nxt.pay.valid = 1'b0;
        s_nxt.pay.last = 1'b0;
        s_nxt.resp.valid = 1'b0;
        s_nxt.pix_valid = 1'b0;
        s_nxt.pix_last = 1'b0;
        // Turnaround: one-way links never answer and keep their state.
        // The clear comes first so that an error or a packet that completes
        // in the same cycle survives for the next turnaround.
        if (TURNAROUND && BIDIR_LINK) begin
            s_nxt.resp.valid = 1'b1;
            s_nxt.resp.read_cmd = s_r.read_cmd;
            s_nxt.resp.max_return = s_r.max_ret;
            if (s_r.last_kind == LAST_READ) begin
                s_nxt.resp.ack = 1'b0;
                s_nxt.resp.err_report = s_r.err;
                s_nxt.resp.read = !s_r.err || s_r.fixed;
            end else begin
                s_nxt.resp.ack = !s_r.err;
                s_nxt.resp.err_report = s_r.err;
                s_nxt.resp.read = 1'b0;
            end
            // Errors from this transmission are now reported
            s_nxt.err = 1'b0;
            s_nxt.fixed = 1'b0;
            s_nxt.last_kind = LAST_NONE;
        end
        if (new_pkt) begin
            // Identifier byte: choose how many header bytes precede the check byte
            s_nxt.dt = RX.data[5:0];
            s_nxt.pos = 3'h0;
            s_nxt.first = 1'b1;
            s_nxt.st = ST_HEAD;
            if (is_short_write(RX.data[5:0])) begin
                s_nxt.cnt = {13'h0000, RX.data[5:3]};
            end else if (RX.data[5:0] == `DT_READ_REQ) begin
                s_nxt.cnt = {13'h0000, `READ_HDR_BYTES};
            end else if (RX.data[5:0] == `DT_MAX_RETURN) begin
                s_nxt.cnt = {13'h0000, `LIMIT_HDR_BYTES};
            end else if (is_long(RX.data[5:0])) begin
                s_nxt.cnt = {13'h0000, `WC_HDR_BYTES};
            end else begin
                // Types outside this block are skipped up to the next packet
                s_nxt.cnt = 16'h0000;
                s_nxt.st = ST_SKIP;
            end
        end else if (byte_in) begin
            case (s_r.st)
                ST_HEAD: begin
                    if (s_r.cnt != 16'h0000) begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                        s_nxt.pos = s_r.pos + 3'h1;
                        if (is_short_write(s_r.dt) || s_r.dt == `DT_READ_REQ) begin
                            s_nxt.cmd.valid = 1'b1;
                            s_nxt.cmd.param = (s_r.pos != 3'h0);
                            s_nxt.cmd.data = RX.data;
                            if (s_r.pos == 3'h0) begin
                                s_nxt.read_cmd = RX.data;
                            end
                        end else if (s_r.pos == 3'h0) begin
                            s_nxt.lim[7:0] = RX.data;
                            s_nxt.wc[7:0] = RX.data;
                        end else begin
                            s_nxt.lim[15:8] = RX.data;
                            s_nxt.wc[15:8] = RX.data;
                        end
                    end else begin
                        // Check byte closes the header
                        s_nxt.err = s_nxt.err | ECC_ERR;
                        s_nxt.fixed = s_nxt.fixed | (ECC_ERR && ECC_FIXED);
                        s_nxt.st = ST_IDLE;
                        if (s_r.dt == `DT_MAX_RETURN) begin
                            if (BIDIR_LINK && !hard_err) begin
                                s_nxt.max_ret = s_r.lim;
                            end
                        end else if (s_r.dt == `DT_READ_REQ) begin
                            s_nxt.last_kind = LAST_READ;
                        end else if (is_short_write(s_r.dt)) begin
                            s_nxt.last_kind = LAST_WRITE;
                        end else if (s_r.wc == 16'h0000) begin
                            s_nxt.st = ST_CSUM;
                            s_nxt.cnt = `CSUM_BYTES;
                        end else begin
                            s_nxt.st = ST_LPAY;
                            s_nxt.cnt = s_r.wc;
                        end
                    end
                end
                ST_LPAY: begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                    s_nxt.first = 1'b0;
                    if (s_r.cnt == 16'h0001) begin
                        s_nxt.st = ST_CSUM;
                        s_nxt.cnt = `CSUM_BYTES;
                    end
                    if (s_r.dt == `DT_LONG_WRITE && s_r.first) begin
                        s_nxt.cmd.valid = 1'b1;
                        s_nxt.cmd.param = 1'b0;
                        s_nxt.cmd.data = RX.data;
                    end else if (s_r.dt == `DT_PIX16 || s_r.dt == `DT_PIX18) begin
                        s_nxt.pix_valid = 1'b1;
                        s_nxt.pix_last = (s_r.cnt == 16'h0001);
                        s_nxt.pix18 = (s_r.dt == `DT_PIX18);
                        s_nxt.pix_byte = RX.data;
                    end else if (s_r.dt != `DT_NULL) begin
                        s_nxt.pay.valid = 1'b1;
                        s_nxt.pay.last = (s_r.cnt == 16'h0001);
                        s_nxt.pay.ptype = s_r.dt;
                        s_nxt.pay.data = RX.data;
                    end
                end
                ST_CSUM: begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                    if (s_r.cnt == 16'h0001) begin
                        s_nxt.err = s_nxt.err | CSUM_ERR;
                        s_nxt.st = ST_IDLE;
                        if (s_r.dt == `DT_LONG_WRITE) begin
                            s_nxt.last_kind = LAST_WRITE;
                        end
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    // Stray bytes outside a packet carry nothing
                end
                default: begin
                    s_nxt.st = ST_IDLE;
                end
            endcase
        end
    end

    // State register; the return limit restarts at one
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.last_kind <= LAST_NONE;
            s_r.max_ret <= `MAX_RET_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pixel bytes are registered once more inside the unpacker
    pixel_unpacker u_unpack (
        .clk      (CLOCK),
        .srst     (SRST),
        .in_valid (s_r.pix_valid),
        .in_last  (s_r.pix_last),
        .in_pix18 (s_r.pix18),
        .in_byte  (s_r.pix_byte),
        .flush    (new_pkt),
        .pix      (PIXEL)
    );

    assign CMD = s_r.cmd;
    assign PAYLOAD = s_r.pay;
    assign RESP = s_r.resp;
    assign MAX_RETURN = s_r.max_ret;

    a_limit_reset_one: assert property (@(posedge CLOCK)
        $fell(SRST) |-> MAX_RETURN == `MAX_RET_RESET)
        else $error("Return limit not one after reset");

    a_oneway_no_answer: assert property (@(posedge CLOCK) disable iff (SRST)
        (TURNAROUND && !BIDIR_LINK) |=> !RESP.valid)
        else $error("One-way link answered a turnaround");

    a_oneway_limit_kept: assert property (@(posedge CLOCK) disable iff (SRST)
        !BIDIR_LINK |=> $stable(MAX_RETURN))
        else $error("One-way link changed its return limit");

    a_write_plain_ack: assert property (@(posedge CLOCK) disable iff (SRST)
        (TURNAROUND && BIDIR_LINK && s_r.last_kind == LAST_WRITE && !s_r.err)
        |=> RESP.valid && RESP.ack && !RESP.err_report && !RESP.read)
        else $error("Clean write not acknowledged");

    a_write_err_report: assert property (@(posedge CLOCK) disable iff (SRST)
        (TURNAROUND && BIDIR_LINK && s_r.last_kind == LAST_WRITE && s_r.err)
        |=> RESP.valid && RESP.err_report && !RESP.ack)
        else $error("Faulty write not reported");

    a_read_clean_data: assert property (@(posedge CLOCK) disable iff (SRST)
        (TURNAROUND && BIDIR_LINK && s_r.last_kind == LAST_READ && !s_r.err)
        |=> RESP.valid && RESP.read && !RESP.err_report
            && RESP.read_cmd == $past(s_r.read_cmd))
        else $error("Clean read not answered with data");

    a_read_fixed_both: assert property (@(posedge CLOCK) disable iff (SRST)
        (TURNAROUND && BIDIR_LINK && s_r.last_kind == LAST_READ && s_r.err)
        |=> RESP.err_report && (RESP.read == $past(s_r.fixed)))
        else $error("Faulty read answered wrongly");

    a_limit_update: assert property (@(posedge CLOCK) disable iff (SRST)
        (byte_in && s_r.st == ST_HEAD && s_r.dt == `DT_MAX_RETURN
            && s_r.cnt == 16'h0000 && BIDIR_LINK && !hard_err)
        |=> MAX_RETURN == $past(s_r.lim))
        else $error("Return limit not taken from command");

    a_count_to_csum: assert property (@(posedge CLOCK) disable iff (SRST)
        (byte_in && s_r.st == ST_LPAY && s_r.cnt == 16'h0001)
        |=> s_r.st == ST_CSUM ##0 s_r.cnt == `CSUM_BYTES)
        else $error("Checksum not located after payload");

    a_long_cmd_first: assert property (@(posedge CLOCK) disable iff (SRST)
        (byte_in && s_r.st == ST_LPAY && s_r.dt == `DT_LONG_WRITE && s_r.first)
        |=> CMD.valid && !CMD.param && !PAYLOAD.valid)
        else $error("Long write command byte misplaced");

    a_null_dropped: assert property (@(posedge CLOCK) disable iff (SRST)
        (byte_in && s_r.st == ST_LPAY && s_r.dt == `DT_NULL)
        |=> !PAYLOAD.valid && !CMD.valid)
        else $error("Null payload was passed on");

endmodule
`default_nettype wire

// File: verilog/pixel_unpacker.sv
// Unpacks 16-bit and packed 18-bit pixel payload bytes into pixels.
// Assumes bytes arrive in link order, first bit of each component in bit 0.
`timescale 1ns/1ns
`default_nettype none
`include "link_decoder_consts.svh"

module pixel_unpacker
    import link_decoder_pkg::*;
(
    input  wire logic       clk,       // Byte clock
    input  wire logic       srst,      // Synchronous reset
    input  wire logic       in_valid,  // Payload byte present
    input  wire logic       in_last,   // Last byte of the line
    input  wire logic       in_pix18,  // High: 18-bit packed, low: 16-bit
    input  wire logic [7:0] in_byte,   // Payload byte
    input  wire logic       flush,     // New packet, drop partial bits
    output pixel_t          pix        // Registered pixel
);

    unpack_regs_t s_r;
    unpack_regs_t s_nxt;
    logic [4:0]   width;
    logic [31:0]  merged;
    logic [5:0]   fill_w;

    // Bits accumulate at the top of the fill; a full pixel leaves from bit 0
    always_comb begin
        s_nxt = s_r;
        s_nxt.pix.valid = 1'b0;
        s_nxt.pix.last = 1'b0;
        width = in_pix18 ? `PIX18_BITS : `PIX16_BITS;
        merged = s_r.acc | ({24'h000000, in_byte} << s_r.fill);
        fill_w = {1'b0, s_r.fill} + 6'h08;
        if (flush) begin
            s_nxt.acc = 32'h00000000;
            s_nxt.fill = 5'h00;
        end else if (in_valid) begin
            if (fill_w >= {1'b0, width}) begin
                s_nxt.pix.valid = 1'b1;
                s_nxt.pix.last = in_last;
                if (in_pix18) begin
                    s_nxt.pix.red = merged[5:0];
                    s_nxt.pix.green = merged[11:6];
                    s_nxt.pix.blue = merged[17:12];
                end else begin
                    s_nxt.pix.red = {1'b0, merged[4:0]};
                    s_nxt.pix.green = merged[10:5];
                    s_nxt.pix.blue = {1'b0, merged[15:11]};
                end
                s_nxt.acc = merged >> width;
                s_nxt.fill = 5'(fill_w - {1'b0, width});
            end else begin
                s_nxt.acc = merged;
                s_nxt.fill = fill_w[4:0];
            end
            // Leftover bits of a partial byte never leak into the next line
            if (in_last) begin
                s_nxt.acc = 32'h00000000;
                s_nxt.fill = 5'h00;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pix = s_r.pix;

    a_line_clean_start: assert property (@(posedge clk) disable iff (srst)
        (in_valid && in_last && !flush) |=> (s_r.fill == 5'h00 && s_r.acc == 32'h00000000))
        else $error("Partial bits survived the end of a line");

endmodule
`default_nettype wire
